// [inc/usf_params.svh]
/*
 Register offsets, field positions, widths and counts of the
 UART status flag block. Assumes an APB slave with 32-bit data.
*/
// Overview of operation
// - Transmit buffer empty flag reads 0 while a character waits, 1 when empty.
// - Transmit done flag, status bit 6, set at reset and when idle with buffer empty.
// - Transmit done clears after flagged status read then data write, enable rise or break.
// - Transmit done reads clear while sending, set once all activity has ended.
// - Receive full flag, status bit 5, sets when a character enters the data register.
// - Receive full clears only by flagged status read followed by a data read.
// - Idle flag, status bit 4, sets after one character time of high after activity.
// - Count select 0 counts idle bit times from just after the start bit.
// - Idle threshold is 10 or 11 bit times by the character length select.
// - Count select 1 starts counting only after the stop bits.
// - Buffer empty set at reset and on move to shifter; cleared by status read, data write.
// - Idle clears by status read then data read; rearms only after a new received character.
`ifndef USF_PARAMS_SVH
`define USF_PARAMS_SVH

`define USF_ADDR_W        8
`define USF_OFF_DATA      8'h00
`define USF_OFF_STATUS    8'h04
`define USF_OFF_CTRL      8'h08
`define USF_OFF_ISTS      8'h0c
`define USF_OFF_ICLR      8'h10
`define USF_OFF_IEN       8'h14

`define USF_ST_TX_BUFFER_EMPTY_FLAG       7
`define USF_ST_TC         6
`define USF_ST_RX_BUFFER_FULL_FLAG       5
`define USF_ST_IDLE       4

`define USF_CT_TX_ON      0
`define USF_CT_SBK        1
`define USF_CT_MSEL       2
`define USF_CT_ILT        3

`define USF_EV_LSB        4
`define USF_CNT_W         4
`define USF_IDLE_BITS_8   4'ha
`define USF_IDLE_BITS_9   4'hb

`endif

// [inc/usf_pkg.sv]
/*
 Types of the UART status flag block.
 Assumes usf_params.svh for widths.
*/
`include "usf_params.svh"

package usf_pkg;

    // Whole block state, registered as one word
    typedef struct packed {
        logic [1:0]             rxd_sync;
        logic                   ready;
        logic [31:0]            rdata;
        logic                   err;
        logic                   tx_buffer_empty_flag;
        logic                   tc;
        logic                   rx_buffer_full_flag;
        logic                   idle;
        logic                   tx_buffer_empty_flag_arm;
        logic                   tc_arm;
        logic                   rx_buffer_full_flag_arm;
        logic                   idle_arm;
        logic                   tc_pend;
        logic                   idle_allow;
        logic                   cnt_en;
        logic [`USF_CNT_W-1:0]  cnt;
        logic                   tx_on;
        logic                   send_break_bit;
        logic                   m_sel;
        logic                   idle_count_after_stop_select;
        logic [3:0]             ists;
        logic [3:0]             ien;
        logic                   irq;
        logic                   data_wr;
        logic                   data_rd;
    } usf_state_t;

    // Line-side events from the shifters
    typedef struct packed {
        logic tx_move;
        logic tx_active;
        logic rx_move;
        logic rx_start;
        logic rx_stop_done;
        logic bit_tick;
    } usf_line_t;

endpackage

// [design/usf_top.sv]
/*
 UART status flags: buffer empty, transmit done, receive full and
 idle line, with an APB register slave and a level interrupt.
 Assumes the shifters, baud tick and data path live outside on pclk;
 only rxd comes from a pin and is synchronised here.
*/
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "usf_params.svh"

module usf_top (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`USF_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire usf_pkg::usf_line_t     line,
    input  wire logic                   rxd,
    output logic                        tx_on,
    output logic                        send_break,
    output logic                        size_sel,
    output logic                        idle_sel,
    output logic                        data_wr,
    output logic                        data_rd,
    output logic                        irq
);

    usf_pkg::usf_state_t s_q;
    usf_pkg::usf_state_t s_d;

    function automatic logic hit(input logic [`USF_ADDR_W-1:0] a,
                                 input logic [`USF_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [3:0] flags(input usf_pkg::usf_state_t s);
        flags = {s.tx_buffer_empty_flag, s.tc & ~line.tx_active, s.rx_buffer_full_flag, s.idle};
    endfunction

    logic                  acc;
    logic                  wr;
    logic                  rd;
    logic                  st_rd;
    logic                  dat_wr;
    logic                  dat_rd;
    logic                  ctl_wr;
    logic                  tc_clr;
    logic                  rx_hi;
    logic                  idle_hit;
    logic [`USF_CNT_W-1:0] thresh;
    logic [3:0]            ev;
    logic [3:0]            cur;
    logic                  mapped;

    always_comb begin
        s_d = s_q;
        s_d.rxd_sync = {s_q.rxd_sync[0], rxd};
        rx_hi = s_q.rxd_sync[1];

        // Access completes on the second access cycle
        acc = psel & penable & s_q.ready;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        mapped = hit(paddr, `USF_OFF_DATA) | hit(paddr, `USF_OFF_STATUS)
               | hit(paddr, `USF_OFF_CTRL) | hit(paddr, `USF_OFF_ISTS)
               | hit(paddr, `USF_OFF_ICLR) | hit(paddr, `USF_OFF_IEN);
        st_rd = rd & hit(paddr, `USF_OFF_STATUS);
        dat_wr = wr & hit(paddr, `USF_OFF_DATA);
        dat_rd = rd & hit(paddr, `USF_OFF_DATA);
        ctl_wr = wr & hit(paddr, `USF_OFF_CTRL);
        cur = flags(s_q);

        s_d.ready = psel & penable & ~s_q.ready;
        s_d.err = psel & penable & ~s_q.ready & ~mapped;
        s_d.rdata = 32'h0;
        if (psel & penable & ~s_q.ready & ~pwrite) begin
            if (hit(paddr, `USF_OFF_STATUS))
                s_d.rdata = {24'h0, cur, 4'h0};
            else if (hit(paddr, `USF_OFF_CTRL))
                s_d.rdata = {28'h0, s_q.idle_count_after_stop_select, s_q.m_sel, s_q.send_break_bit, s_q.tx_on};
            else if (hit(paddr, `USF_OFF_ISTS))
                s_d.rdata = {24'h0, s_q.ists, 4'h0};
            else if (hit(paddr, `USF_OFF_IEN))
                s_d.rdata = {24'h0, s_q.ien, 4'h0};
        end

        s_d.data_wr = dat_wr;
        s_d.data_rd = dat_rd;

        // Control register
        tc_clr = dat_wr;
        if (ctl_wr) begin
            s_d.tx_on = pwdata[`USF_CT_TX_ON];
            s_d.send_break_bit = pwdata[`USF_CT_SBK];
            s_d.m_sel = pwdata[`USF_CT_MSEL];
            s_d.idle_count_after_stop_select = pwdata[`USF_CT_ILT];
            if (pwdata[`USF_CT_TX_ON] & ~s_q.tx_on)
                tc_clr = 1'b1;
            if (pwdata[`USF_CT_SBK])
                tc_clr = 1'b1;
        end

        // Armed bits follow the flag seen by the status read
        if (st_rd) begin
            s_d.tx_buffer_empty_flag_arm = cur[3];
            s_d.tc_arm = cur[2];
            s_d.rx_buffer_full_flag_arm = cur[1];
            s_d.idle_arm = cur[0];
        end

        // Buffer empty
        ev = 4'h0;
        if (dat_wr & s_q.tx_buffer_empty_flag_arm) begin
            s_d.tx_buffer_empty_flag = 1'b0;
            s_d.tx_buffer_empty_flag_arm = 1'b0;
        end
        if (line.tx_move) begin
            s_d.tx_buffer_empty_flag = 1'b1;
            ev[3] = ~s_q.tx_buffer_empty_flag;
        end

        // Transmit done
        if (tc_clr & s_q.tc_arm) begin
            s_d.tc = 1'b0;
            s_d.tc_arm = 1'b0;
            s_d.tc_pend = 1'b1;
        end
        if (line.tx_active) begin
            s_d.tc = 1'b0;
            s_d.tc_pend = 1'b0;
        end else if (s_q.tx_buffer_empty_flag & ~s_q.tc_pend & ~(tc_clr & s_q.tc_arm)) begin
            s_d.tc = 1'b1;
            ev[2] = ~s_q.tc;
        end

        // Receive full; new character wins over a clear
        if (dat_rd & s_q.rx_buffer_full_flag_arm) begin
            s_d.rx_buffer_full_flag = 1'b0;
            s_d.rx_buffer_full_flag_arm = 1'b0;
        end
        if (line.rx_move) begin
            s_d.rx_buffer_full_flag = 1'b1;
            s_d.idle_allow = 1'b1;
            ev[1] = 1'b1;
        end

        // Idle line counter
        thresh = s_q.m_sel ? `USF_IDLE_BITS_9 : `USF_IDLE_BITS_8;
        idle_hit = 1'b0;
        if (line.rx_start) begin
            s_d.cnt = '0;
            s_d.cnt_en = ~s_q.idle_count_after_stop_select;
        end else if (line.rx_stop_done & s_q.idle_count_after_stop_select) begin
            s_d.cnt = '0;
            s_d.cnt_en = 1'b1;
        end else if (line.bit_tick & s_q.cnt_en) begin
            if (!rx_hi)
                s_d.cnt = '0;
            else if (s_q.cnt != thresh)
                s_d.cnt = s_q.cnt + `USF_CNT_W'(1);
            if (rx_hi && (s_q.cnt + `USF_CNT_W'(1) == thresh))
                idle_hit = 1'b1;
        end

        if (dat_rd & s_q.idle_arm) begin
            s_d.idle = 1'b0;
            s_d.idle_arm = 1'b0;
        end
        if (idle_hit & s_q.idle_allow & ~line.rx_move) begin
            s_d.idle = 1'b1;
            s_d.idle_allow = 1'b0;
            ev[0] = 1'b1;
        end

        // Interrupt: set wins over clear
        if (wr & hit(paddr, `USF_OFF_ICLR))
            s_d.ists = s_q.ists & ~pwdata[`USF_ST_TX_BUFFER_EMPTY_FLAG:`USF_EV_LSB];
        if (wr & hit(paddr, `USF_OFF_IEN))
            s_d.ien = pwdata[`USF_ST_TX_BUFFER_EMPTY_FLAG:`USF_EV_LSB];
        s_d.ists = s_d.ists | ev;
        s_d.irq = |(s_d.ists & s_d.ien);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.tx_buffer_empty_flag <= 1'b1;
            s_q.tc <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign tx_on = s_q.tx_on;
    assign send_break = s_q.send_break_bit;
    assign size_sel = s_q.m_sel;
    assign idle_sel = s_q.idle_count_after_stop_select;
    assign data_wr = s_q.data_wr;
    assign data_rd = s_q.data_rd;
    assign irq = s_q.irq;

endmodule // usf_top

`default_nettype wire

// [tb/usf_chk.sv]
/* Port checker of usf_top.
 Assumes an APB master that keeps the protocol. */
`timescale 1ns/1ps
`default_nettype none
`include "usf_params.svh"
module usf_chk (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`USF_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire usf_pkg::usf_line_t     line,
    input wire logic                   rxd,
    input wire logic                   tx_on,
    input wire logic                   send_break,
    input wire logic                   size_sel,
    input wire logic                   idle_sel,
    input wire logic                   data_wr,
    input wire logic                   data_rd,
    input wire logic                   irq
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire acc = psel && penable && pready;
a_pready_late: assert property (psel && penable && !pready |=> pready) else $error("pready late");
a_pready_pulse: assert property (pready |=> !pready) else $error("pready long");
a_err_unmap: assert property (acc && paddr > 8'h14 |-> pslverr) else $error("no slverr");
a_err_mapped: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 8'h14 |-> !pslverr) else $error("slverr");
a_rd_high: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("high bits");
a_tc_busy: assert property (acc && !pwrite && paddr == 8'h04 && $past(line.tx_active) |-> !prdata[6])
    else $error("tc while busy");
a_data_wr: assert property (acc && pwrite && paddr == 8'h00 |=> data_wr) else $error("no data_wr");
a_data_rd: assert property (acc && !pwrite && paddr == 8'h00 |=> data_rd) else $error("no data_rd");
a_ctrl_bits: assert property (acc && pwrite && paddr == 8'h08 |=>
    tx_on == $past(pwdata[0]) && send_break == $past(pwdata[1])) else $error("ctrl bits");
endmodule // usf_chk
bind usf_top usf_chk i_usf_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line(line), .rxd(rxd), .tx_on(tx_on), .send_break(send_break),
    .size_sel(size_sel), .idle_sel(idle_sel), .data_wr(data_wr), .data_rd(data_rd), .irq(irq));
`default_nettype wire

// [tb/usf_rmt.sv]
/* Remote serial end and shifter events.
 Assumes a bit time of four pclk cycles, idle line high. */
`timescale 1ns/1ps
`default_nettype none
module usf_rmt (
    input  wire logic               pclk,
    output var usf_pkg::usf_line_t  line,
    output var logic                rxd
);
logic [1:0] ph;
initial begin
    line = '0;
    rxd = 1'b1;
    ph = 2'h0;
end
always @(posedge pclk) begin
    ph <= ph + 2'h1;
    line.bit_tick <= (ph == 2'h3);
end
task automatic tick;
    do @(posedge pclk); while (!line.bit_tick);
endtask
task automatic rx_char(input logic [7:0] d);
    int i;
    tick;
    rxd <= 1'b0;
    line.rx_start <= 1'b1;
    @(posedge pclk) line.rx_start <= 1'b0;
    for (i = 0; i < 8; i++) begin
        tick;
        rxd <= d[i];
    end
    tick;
    rxd <= 1'b1;
    tick;
    line.rx_move <= 1'b1;
    line.rx_stop_done <= 1'b1;
    @(posedge pclk) line.rx_move <= 1'b0;
    line.rx_stop_done <= 1'b0;
endtask
task automatic tx_set(input logic a);
    line.tx_move <= a;
    line.tx_active <= a;
    @(posedge pclk) line.tx_move <= 1'b0;
endtask
endmodule // usf_rmt
`default_nettype wire

// [tb/uart_status_flags_tb.sv]
/* Testbench of usf_top through APB and the remote end.
 Assumes usf_rmt drives the line side. */
`timescale 1ns/1ps
`default_nettype none
module uart_status_flags_tb;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, rxd;
logic tx_on, send_break, size_sel, idle_sel, data_wr, data_rd, irq;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, rd;
usf_pkg::usf_line_t line;
int err_total = 0, n_tests = 0, i;
usf_top i_usf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line(line),
    .rxd(rxd), .tx_on(tx_on), .send_break(send_break), .size_sel(size_sel), .idle_sel(idle_sel),
    .data_wr(data_wr), .data_rd(data_rd), .irq(irq));
usf_rmt i_usf_rmt (.pclk(pclk), .line(line), .rxd(rxd));
initial begin
    forever #2.5 pclk = ~pclk;
end
task automatic close_out;
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
        err_total++;
        $display("Error %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic st(input logic [7:0] e);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", {24'h0, e}, rd);
endtask
initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    close_out;
end
initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    st(8'hc0);
    apb(1'b1, 8'h00, 32'h0);
    st(8'h00);
    for (i = 0; i < 2; i++) begin
        i_usf_rmt.tx_set(1'b1);
        st(8'h80);
        i_usf_rmt.tx_set(1'b0);
        st(8'hc0);
        apb(1'b1, 8'h08, 32'(i + 1));
        st(8'h80);
        apb(1'b1, 8'h08, 32'h0);
    end
    // The queued break is shifted out, then the transmitter goes idle
    i_usf_rmt.tx_set(1'b1);
    i_usf_rmt.tx_set(1'b0);
    apb(1'b1, 8'h14, 32'h20);
    i_usf_rmt.rx_char(8'h55);
    st(8'he0);
    chk("irq", 32'h1, 32'(irq));
    repeat (44) @(posedge pclk);
    st(8'hf0);
    apb(1'b0, 8'h00, 32'h0);
    st(8'hc0);
    apb(1'b1, 8'h10, 32'h20);
    @(posedge pclk);
    chk("irq", 32'h0, 32'(irq));
    repeat (60) @(posedge pclk);
    st(8'hc0);
    i_usf_rmt.rx_char(8'hff);
    apb(1'b0, 8'h00, 32'h0);
    repeat (8) @(posedge pclk);
    st(8'hf0);
    apb(1'b0, 8'h00, 32'h0);
    apb(1'b1, 8'h08, 32'hc);
    apb(1'b0, 8'h08, 32'h0);
    chk("ctrl", 32'hc, rd);
    chk("sel", 32'h3, 32'({size_sel, idle_sel}));
    i_usf_rmt.rx_char(8'hff);
    repeat (32) @(posedge pclk);
    st(8'he0);
    repeat (12) @(posedge pclk);
    st(8'hf0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    apb(1'b1, 8'h14, 32'h0);
    @(posedge pclk);
    chk("irq", 32'h0, 32'(irq));
    close_out;
end
endmodule // uart_status_flags_tb
`default_nettype wire
